// File: logic/ssdp_core.sv
// Data path and status flags of a synchronous serial port.
// Assumes a peer that changes sync and data on falling bit-clock edges;
// the port samples and drives on rising edges, found by oversampling.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "ssdp_regs.svh"

module ssdp_core #(
    parameter int unsigned MAX_SLOTS = 32
) (
    input wire logic i_clk, // 250 MHz system clock
    input wire logic i_rst, // hardware reset, synchronous, high
    input wire logic i_soft_rst, // software reset pulse
    input wire logic i_port_rst, // port-individual or stop reset pulse
    input wire logic [7:0] i_addr, // register byte address
    input wire logic [23:0] i_wdata, // register write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [23:0] o_rdata, // read data, cycle after strobe
    input wire ssdp_pkg::ssdp_pins_s i_pins, // serial pins in
    output logic o_txd, // serial data out
    output logic o_txd_oe_n, // low while data out is driven
    output logic o_rx_irq, // receive request, normal vector
    output logic o_rx_irq_exc, // receive request, exception vector
    output logic o_tx_irq, // transmit request, normal vector
    output logic o_tx_irq_exc // transmit request, exception vector
);
    import ssdp_pkg::*;

    if (MAX_SLOTS < 1 || MAX_SLOTS > 63) begin : gen_slot_check
        $error("MAX_SLOTS must lie in 1..63");
    end

    localparam logic [5:0] SLOT_LIM = 6'(MAX_SLOTS);

    function automatic logic [4:0] wl_bits(input logic [1:0] sel);
        case (sel)
            2'h0: wl_bits = `SSDP_WL8;
            2'h1: wl_bits = `SSDP_WL12;
            2'h2: wl_bits = `SSDP_WL16;
            default: wl_bits = `SSDP_WL24;
        endcase
    endfunction

    // Shifts one bit into the receive shifter in the chosen direction.
    function automatic ssdp_word_t shift_in(input ssdp_word_t w,
                                            input logic b, input logic lsb);
        shift_in = lsb ? {b, w[23:1]} : {w[22:0], b};
    endfunction

    // Moves a finished word into the high bits; low bits become zero.
    function automatic ssdp_word_t justify(input ssdp_word_t w,
                                           input logic [4:0] n,
                                           input logic lsb);
        logic [4:0] gap;
        gap = `SSDP_WL24 - n;
        justify = lsb ? w : (w << gap);
    endfunction

    function automatic logic out_bit(input ssdp_word_t w, input logic lsb);
        out_bit = lsb ? w[0] : w[23];
    endfunction

    function automatic ssdp_word_t shift_out(input ssdp_word_t w,
                                             input logic lsb);
        shift_out = lsb ? (w >> 1) : (w << 1);
    endfunction

    ssdp_ctrl_s ctrl;
    logic flag_clr;
    logic [1:0] bclk_q, fs_q, rxd_q;
    logic bclk_d, fs_prev, bit_edge, sync_now;
    logic [4:0] wl;
    ssdp_word_t rx_sr, rx_data, next_rx_sr;
    logic [4:0] rx_cnt, next_rx_cnt;
    logic rx_busy, rx_mark, rx_start, rx_done, next_mark, rx_word_ev;
    logic rx_frame_start_flag, rx_overrun_flag, rx_full_flag, roe_armed;
    ssdp_word_t tx_data, tx_sr, tx_load;
    logic [4:0] tx_cnt;
    logic [5:0] tx_slots;
    logic tx_busy, tx_start, tx_hold_null;
    logic tx_empty_flag, tx_underrun_flag, tue_armed, tx_consume, tx_underrun;
    logic wr_tx, wr_null, rd_rx, rd_st;

    assign flag_clr = i_rst | i_soft_rst | i_port_rst;
    assign wl = wl_bits(ctrl.word_len_sel);
    assign wr_tx = i_wr & (i_addr == `SSDP_OFF_TXDATA);
    assign wr_null = i_wr & (i_addr == `SSDP_OFF_NULL);
    assign rd_rx = i_rd & (i_addr == `SSDP_OFF_RXDATA);
    assign rd_st = i_rd & (i_addr == `SSDP_OFF_STATUS);

    always_ff @(posedge i_clk) begin
        if (i_rst || i_soft_rst) begin
            ctrl <= `SSDP_CTRL_RST;
        end else if (i_wr && i_addr == `SSDP_OFF_CTRL) begin
            ctrl <= ssdp_ctrl_s'(i_wdata[`SSDP_CTRL_W-1:0]);
        end
    end

    // Pin synchronisers and bit-clock rising-edge finder.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bclk_q <= 2'h0;
            fs_q <= 2'h0;
            rxd_q <= 2'h0;
            bclk_d <= 1'b0;
        end else begin
            bclk_q <= {bclk_q[0], i_pins.bit_clk};
            fs_q <= {fs_q[0], i_pins.frame_sync};
            rxd_q <= {rxd_q[0], i_pins.rx_data};
            bclk_d <= bclk_q[1];
        end
    end

    assign bit_edge = bclk_q[1] & ~bclk_d;

    always_ff @(posedge i_clk) begin
        if (flag_clr) begin
            fs_prev <= 1'b0;
        end else if (bit_edge) begin
            fs_prev <= fs_q[1];
        end
    end

    // Word-wide sync starts on a rising sync; bit-wide on its falling edge.
    assign sync_now = ctrl.rx_sync_length_sel ? (fs_prev & ~fs_q[1])
                                              : (fs_q[1] & ~fs_prev);

    // Receive shifter; network mode runs slots back to back.
    always_comb begin
        rx_start = sync_now | (rx_busy & (rx_cnt == 5'h00));
        next_rx_sr = shift_in(rx_start ? '0 : rx_sr, rxd_q[1],
                              ctrl.shift_direction_bit);
        next_rx_cnt = rx_start ? `SSDP_CNT_ONE : rx_cnt + `SSDP_CNT_ONE;
        rx_done = (next_rx_cnt == wl);
        next_mark = rx_start ? (sync_now | ~ctrl.network_mode) : rx_mark;
    end

    assign rx_word_ev = bit_edge & (sync_now | rx_busy) & rx_done;

    always_ff @(posedge i_clk) begin
        if (flag_clr) begin
            rx_busy <= 1'b0;
            rx_cnt <= 5'h00;
            rx_mark <= 1'b0;
            rx_sr <= '0;
        end else if (bit_edge && (sync_now || rx_busy)) begin
            rx_sr <= next_rx_sr;
            rx_mark <= next_mark;
            rx_cnt <= rx_done ? 5'h00 : next_rx_cnt;
            rx_busy <= rx_done ? ctrl.network_mode : 1'b1;
        end
    end

    // Receive register and flags; setting events beat clears.
    always_ff @(posedge i_clk) begin
        if (flag_clr) begin
            rx_full_flag <= 1'b0;
            rx_overrun_flag <= 1'b0;
            rx_frame_start_flag <= 1'b0;
            roe_armed <= 1'b0;
            rx_data <= '0;
        end else begin
            if (rx_word_ev && !rx_full_flag && ctrl.receive_enable_bit) begin
                rx_full_flag <= 1'b1;
                rx_frame_start_flag <= next_mark;
                rx_data <= justify(next_rx_sr, wl,
                                   ctrl.shift_direction_bit);
            end else if (rd_rx) begin
                rx_full_flag <= 1'b0;
            end
            if (rx_word_ev && rx_full_flag) begin
                rx_overrun_flag <= 1'b1;
            end else if (rd_rx && roe_armed) begin
                rx_overrun_flag <= 1'b0;
            end
            if (rd_st) begin
                roe_armed <= rx_overrun_flag;
            end else if (rd_rx) begin
                roe_armed <= 1'b0;
            end
        end
    end

    // Transmit slots: a sync opens a frame; network mode chains slots.
    assign tx_start = sync_now | (tx_busy & (tx_cnt == wl)
                      & ctrl.network_mode & (tx_slots < SLOT_LIM));
    // LSB-first words are shifted down at load so their low used bit leads.
    // Doing it here keeps a held word right after a word-length change.
    assign tx_load = ctrl.shift_direction_bit
                     ? (tx_data >> (`SSDP_WL24 - wl)) : tx_data;
    assign tx_consume = bit_edge & tx_start & ~tx_empty_flag
                        & (ctrl.transmit_enable_bit | ctrl.network_mode);
    assign tx_underrun = bit_edge & tx_start & tx_empty_flag
                         & ctrl.transmit_enable_bit;

    always_ff @(posedge i_clk) begin
        if (flag_clr) begin
            tx_busy <= 1'b0;
            tx_cnt <= 5'h00;
            tx_slots <= 6'h00;
            tx_sr <= '0;
            o_txd <= 1'b0;
            o_txd_oe_n <= 1'b1;
        end else if (bit_edge) begin
            if (tx_start) begin
                tx_busy <= 1'b1;
                tx_cnt <= `SSDP_CNT_ONE;
                tx_slots <= sync_now ? `SSDP_SLOT_ONE
                                     : tx_slots + `SSDP_SLOT_ONE;
                // An underrun sends the held word again.
                tx_sr <= shift_out(tx_load, ctrl.shift_direction_bit);
                o_txd <= out_bit(tx_load, ctrl.shift_direction_bit);
                o_txd_oe_n <= ~ctrl.transmit_enable_bit | tx_hold_null;
            end else if (tx_busy && tx_cnt < wl) begin
                tx_cnt <= tx_cnt + `SSDP_CNT_ONE;
                tx_sr <= shift_out(tx_sr, ctrl.shift_direction_bit);
                o_txd <= out_bit(tx_sr, ctrl.shift_direction_bit);
            end else if (tx_busy) begin
                tx_busy <= 1'b0;
                o_txd_oe_n <= 1'b1;
            end
        end
    end

    // The held word stays left-justified as written; an underrun resends it.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_data <= '0;
            tx_hold_null <= 1'b0;
        end else if (wr_tx) begin
            tx_data <= i_wdata;
            tx_hold_null <= 1'b0;
        end else if (wr_null) begin
            tx_hold_null <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (flag_clr) begin
            tx_empty_flag <= 1'b1;
            tx_underrun_flag <= 1'b0;
            tue_armed <= 1'b0;
        end else begin
            if (tx_consume) begin
                tx_empty_flag <= 1'b1;
            end else if (wr_tx || wr_null) begin
                tx_empty_flag <= 1'b0;
            end
            if (tx_underrun) begin
                tx_underrun_flag <= 1'b1;
            end else if ((wr_tx || wr_null) && tue_armed) begin
                tx_underrun_flag <= 1'b0;
            end
            if (rd_st) begin
                tue_armed <= tx_underrun_flag;
            end else if (wr_tx || wr_null) begin
                tue_armed <= 1'b0;
            end
        end
    end

    // Flag-derived requests; error flags only pick the vector.
    always_ff @(posedge i_clk) begin
        if (flag_clr) begin
            o_rx_irq <= 1'b0;
            o_rx_irq_exc <= 1'b0;
            o_tx_irq <= 1'b0;
            o_tx_irq_exc <= 1'b0;
        end else begin
            o_rx_irq <= ctrl.rx_irq_enable & rx_full_flag & ~rx_overrun_flag;
            o_rx_irq_exc <= ctrl.rx_irq_enable & rx_full_flag & rx_overrun_flag;
            o_tx_irq <= ctrl.tx_irq_enable & tx_empty_flag & ~tx_underrun_flag;
            o_tx_irq_exc <= ctrl.tx_irq_enable & tx_empty_flag & tx_underrun_flag;
        end
    end

    // Register reads; data stand one cycle, zero otherwise.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (!i_rd) begin
            o_rdata <= '0;
        end else begin
            case (i_addr)
                `SSDP_OFF_STATUS: begin
                    o_rdata <= '0;
                    o_rdata[`SSDP_ST_RFS] <= rx_frame_start_flag;
                    o_rdata[`SSDP_ST_TUE] <= tx_underrun_flag;
                    o_rdata[`SSDP_ST_ROE] <= rx_overrun_flag;
                    o_rdata[`SSDP_ST_TDE] <= tx_empty_flag;
                    o_rdata[`SSDP_ST_RDF] <= rx_full_flag;
                end
                `SSDP_OFF_RXDATA: o_rdata <= rx_data;
                `SSDP_OFF_CTRL: o_rdata <= 24'(ctrl);
                default: o_rdata <= '0;
            endcase
        end
    end

    rx_full_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rx_word_ev && !rx_full_flag && ctrl.receive_enable_bit && !flag_clr
        |=> rx_full_flag && rx_frame_start_flag == $past(next_mark))
        else $error("receive full flag not set on word transfer");

    overrun_drop_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rx_word_ev && rx_full_flag && !flag_clr |=> rx_overrun_flag && $stable(rx_data))
        else $error("overrun not flagged or word not dropped");

    normal_frame_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rx_word_ev && !rx_full_flag && !ctrl.network_mode && ctrl.receive_enable_bit
        && !flag_clr |=> rx_frame_start_flag)
        else $error("frame flag clear in normal mode");

    underrun_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        tx_underrun && !flag_clr |=> tx_underrun_flag && tx_empty_flag)
        else $error("underrun not flagged on empty slot");

    empty_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_tx || wr_null) && !tx_consume && !flag_clr |=> !tx_empty_flag)
        else $error("empty flag not cleared by write");

    null_hiz_a: assert property (@(posedge i_clk) disable iff (i_rst)
        bit_edge && tx_start && tx_hold_null && !flag_clr
        |=> o_txd_oe_n)
        else $error("data out driven in null slot");

    rx_vector_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ctrl.rx_irq_enable && rx_full_flag && rx_overrun_flag && !flag_clr
        |=> o_rx_irq_exc && !o_rx_irq)
        else $error("receive exception vector not selected");

    status_byte_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_st |=> o_rdata[23:`SSDP_ST_W] == '0
        && o_rdata[`SSDP_ST_RDF] == $past(rx_full_flag))
        else $error("status read malformed");

    slot_limit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        tx_slots <= SLOT_LIM)
        else $error("transmit slot count beyond limit");

    tx_vector_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ctrl.tx_irq_enable && tx_empty_flag && tx_underrun_flag && !flag_clr
        |=> o_tx_irq_exc && !o_tx_irq)
        else $error("transmit exception vector not selected");

    flag_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_soft_rst || i_port_rst
        |=> tx_empty_flag && !tx_underrun_flag && !rx_overrun_flag && !rx_full_flag && !rx_frame_start_flag)
        else $error("status flags not reset");
endmodule // ssdp_core

// File: logic/ssdp_pkg.sv
// Types shared by the serial data port core and its bench.
// Assumes the register constants header sits beside it.
package ssdp_pkg;
    // Control bits; low bits of the control register, wlen in bits 1:0.
    typedef struct packed {
        logic rx_irq_enable;
        logic tx_irq_enable;
        logic receive_enable_bit;
        logic transmit_enable_bit;
        logic network_mode;
        logic rx_sync_length_sel;
        logic shift_direction_bit;
        logic [1:0] word_len_sel;
    } ssdp_ctrl_s;

    // Serial pins arriving from the link.
    typedef struct packed {
        logic bit_clk;
        logic frame_sync;
        logic rx_data;
    } ssdp_pins_s;

    typedef logic [23:0] ssdp_word_t;
endpackage

// File: logic/ssdp_regs.svh
// Register offsets, field positions and constants of the serial data port.
// Assumes inclusion by bare name from the core and the bench.
`ifndef SSDP_REGS_SVH
`define SSDP_REGS_SVH
`define SSDP_OFF_STATUS 8'h00
`define SSDP_OFF_RXDATA 8'h04
`define SSDP_OFF_TXDATA 8'h08
`define SSDP_OFF_NULL 8'h0c
`define SSDP_OFF_CTRL 8'h10
`define SSDP_ST_RFS 3
`define SSDP_ST_TUE 4
`define SSDP_ST_ROE 5
`define SSDP_ST_TDE 6
`define SSDP_ST_RDF 7
`define SSDP_ST_W 8
`define SSDP_CTRL_W 9
`define SSDP_CTRL_RST 9'h000
`define SSDP_WL8 5'h08
`define SSDP_WL12 5'h0c
`define SSDP_WL16 5'h10
`define SSDP_WL24 5'h18
`define SSDP_CNT_ONE 5'h01
`define SSDP_SLOT_ONE 6'h01
`endif

// File: verification/ssdp_peer.sv
// Behavioural serial peer: bit clock, frame sync and receive data.
// Assumes the port samples on rising bit-clock edges; the peer moves on
// falling edges and leaves the clock low between frames.
`timescale 1ns/1ps
module ssdp_peer (
    output ssdp_pkg::ssdp_pins_s o_pins, // serial pins toward the port
    input wire logic i_txd, // serial data from the port
    input wire logic i_txd_oe_n // high while the port leaves data undriven
);
    import ssdp_pkg::*;
    ssdp_word_t cap;
    logic z_seen;
    initial begin
        o_pins = '0;
        cap = '0;
        z_seen = 1'b0;
    end
    // Rising edges 1..nb of a frame return the first slot's output bits.
    task automatic pulse(input int idx, input int nb);
        #16 o_pins.bit_clk = 1'b1;
        if (idx >= 1 && idx <= nb) begin
            cap = {cap[22:0], i_txd};
            z_seen = z_seen | i_txd_oe_n;
        end
        #16 o_pins.bit_clk = 1'b0;
    endtask
    task automatic frame(input ssdp_word_t w, input int nb, input logic lsb,
                         input logic bw, input int ns);
        int idx;
        ssdp_word_t v;
        idx = 0;
        cap = '0;
        z_seen = 1'b0;
        #1.3;
        if (bw) begin
            o_pins.frame_sync = 1'b1;
            pulse(-1, nb);
        end
        for (int s = 0; s < ns; s++) begin
            v = (s == 0) ? w : ~w;
            for (int k = 0; k < nb; k++) begin
                o_pins.rx_data = lsb ? v[24 - nb + k] : v[23 - k];
                o_pins.frame_sync = !bw && (s == 0);
                pulse(idx, nb);
                idx++;
            end
        end
        // A released line shows the inverse of its last value.
        o_pins.frame_sync = 1'b0;
        o_pins.rx_data = ~o_pins.rx_data;
        pulse(idx, nb);
    endtask
endmodule // ssdp_peer

// File: verification/sync_serial_data_status_tb_top.sv
// Self-checking bench of the serial data port core with a serial peer.
// Assumes the register offsets of the shared header and the peer model.
`timescale 1ns/1ps
`include "ssdp_regs.svh"
`define CHK(what, exp, got) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("Error %s expected %h seen %h", what, exp, got); \
    end \
end
module sync_serial_data_status_tb_top;
    import ssdp_pkg::*;
    logic i_clk, i_rst, i_soft_rst, i_port_rst, i_wr, i_rd;
    logic [7:0] i_addr;
    ssdp_word_t i_wdata, o_rdata, d, t, w;
    ssdp_pins_s i_pins;
    logic o_txd, o_txd_oe_n, o_rx_irq, o_rx_irq_exc, o_tx_irq, o_tx_irq_exc;
    logic [3:0] irqs;
    assign irqs = {o_rx_irq, o_rx_irq_exc, o_tx_irq, o_tx_irq_exc};
    int failures, cmp_count, seed, nb;
    ssdp_ctrl_s c;
    ssdp_core #(.MAX_SLOTS(32)) ssdp_core_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_soft_rst(i_soft_rst), .i_port_rst(i_port_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_pins(i_pins), .o_txd(o_txd), .o_txd_oe_n(o_txd_oe_n),
        .o_rx_irq(o_rx_irq), .o_rx_irq_exc(o_rx_irq_exc),
        .o_tx_irq(o_tx_irq), .o_tx_irq_exc(o_tx_irq_exc));
    ssdp_peer ssdp_peer_inst (.o_pins(i_pins), .i_txd(o_txd),
        .i_txd_oe_n(o_txd_oe_n));
    initial i_clk = 1'b0;
    always #2 i_clk = ~i_clk;
    function automatic int nbits(input logic [1:0] wl);
        return (wl == 2'h0) ? 8 : (wl == 2'h1) ? 12 : (wl == 2'h2) ? 16 : 24;
    endfunction
    function automatic ssdp_word_t rx_exp(input ssdp_word_t v, input int n);
        return v & ~((24'h1 << (24 - n)) - 24'h1);
    endfunction
    function automatic ssdp_word_t tx_exp(input ssdp_word_t v, input int n,
                                          input logic lsb);
        ssdp_word_t r;
        r = '0;
        for (int k = 0; k < n; k++) begin
            r = {r[22:0], lsb ? v[24 - n + k] : v[23 - k]};
        end
        return r;
    endfunction
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input ssdp_word_t v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output ssdp_word_t v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic chk_st(input logic [7:0] m, input logic [7:0] e);
        ssdp_word_t s;
        rd(`SSDP_OFF_STATUS, s);
        `CHK("status", {16'h0, e}, s & {16'h0, m})
    endtask
    task automatic wait_rdf(output ssdp_word_t s);
        for (int n = 0; n < 300; n++) begin
            rd(`SSDP_OFF_STATUS, s);
            if (s[`SSDP_ST_RDF] === 1'b1) return;
        end
        `CHK("receive wait", 1'b1, 1'b0)
        stop_test();
    endtask
    task automatic frame1(input ssdp_word_t v);
        ssdp_peer_inst.frame(v, nb, c.shift_direction_bit,
                             c.rx_sync_length_sel, 1);
        repeat (10) @(posedge i_clk);
    endtask
    initial begin
        repeat (100000) @(posedge i_clk);
        `CHK("watchdog", 1'b0, 1'b1)
        stop_test();
    end
    initial begin
        seed = 32'h1364;
        failures = 0;
        cmp_count = 0;
        {i_rst, i_soft_rst, i_port_rst, i_wr, i_rd} = 5'h10;
        i_addr = 8'h00;
        i_wdata = '0;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(`SSDP_OFF_STATUS, d);
        `CHK("status reset", 24'h000040, d)
        rd(8'h20, d);
        `CHK("unmapped", 24'h0, d)
        rd(`SSDP_OFF_TXDATA, d);
        `CHK("tx read", 24'h0, d)
        for (int i = 0; i < 4; i++) begin
            c = '0;
            c.receive_enable_bit = 1'b1;
            c.transmit_enable_bit = 1'b1;
            c.rx_sync_length_sel = 1'($random(seed));
            c.shift_direction_bit = 1'($random(seed));
            c.word_len_sel = 2'(i);
            nb = nbits(c.word_len_sel);
            wr(`SSDP_OFF_CTRL, {15'h0, c});
            t = 24'($random(seed));
            w = 24'($random(seed));
            wr(`SSDP_OFF_TXDATA, t);
            frame1(w);
            chk_st(8'hf8, 8'hc8);
            rd(`SSDP_OFF_RXDATA, d);
            `CHK("rx word", rx_exp(w, nb), d)
            d = ssdp_peer_inst.cap & (24'hffffff >> (24 - nb));
            w = tx_exp(t, nb, c.shift_direction_bit);
            `CHK("tx bits", w, d)
            `CHK("tx driven", 1'b0, ssdp_peer_inst.z_seen)
            chk_st(8'h80, 8'h00);
            $display("test word length %0d done", nb);
        end
        c.rx_irq_enable = 1'b1;
        c.tx_irq_enable = 1'b1;
        c.word_len_sel = 2'h0;
        nb = 8;
        wr(`SSDP_OFF_CTRL, {15'h0, c});
        w = 24'($random(seed));
        frame1(w);
        d = ssdp_peer_inst.cap & 24'hff;
        `CHK("tx again", tx_exp(t, 8, c.shift_direction_bit), d)
        `CHK("irq", 4'b1001, irqs)
        frame1(~w);
        `CHK("irq", 4'b0101, irqs)
        chk_st(8'hf8, 8'hf8);
        rd(`SSDP_OFF_RXDATA, d);
        `CHK("kept word", rx_exp(w, 8), d)
        chk_st(8'h20, 8'h00);
        wr(`SSDP_OFF_TXDATA, 24'($random(seed)));
        chk_st(8'h50, 8'h00);
        repeat (2) @(posedge i_clk);
        `CHK("irq idle", 4'b0000, irqs)
        $display("test overrun and underrun done");
        wr(`SSDP_OFF_NULL, 24'($random(seed)));
        frame1(24'($random(seed)));
        `CHK("null slot", 1'b1, ssdp_peer_inst.z_seen)
        chk_st(8'hd8, 8'hc8);
        @(posedge i_clk);
        i_port_rst <= 1'b1;
        @(posedge i_clk);
        i_port_rst <= 1'b0;
        rd(`SSDP_OFF_STATUS, d);
        `CHK("port reset", 24'h000040, d)
        rd(`SSDP_OFF_CTRL, d);
        `CHK("ctrl kept", {15'h0, c}, d)
        $display("test null slot and port reset done");
        c.network_mode = 1'b1;
        c.transmit_enable_bit = 1'b0;
        c.rx_sync_length_sel = 1'b0;
        wr(`SSDP_OFF_CTRL, {15'h0, c});
        wr(`SSDP_OFF_TXDATA, 24'($random(seed)));
        w = 24'($random(seed));
        fork
            ssdp_peer_inst.frame(w, 8, c.shift_direction_bit, 1'b0, 2);
            begin
                wait_rdf(d);
                `CHK("first slot", 1'b1, d[`SSDP_ST_RFS])
                rd(`SSDP_OFF_RXDATA, d);
                `CHK("slot word", rx_exp(w, 8), d)
                wait_rdf(d);
                `CHK("later slot", 1'b0, d[`SSDP_ST_RFS])
                rd(`SSDP_OFF_RXDATA, d);
                `CHK("slot word", rx_exp(~w, 8), d)
            end
        join
        repeat (10) @(posedge i_clk);
        chk_st(8'h40, 8'h40);
        @(posedge i_clk);
        i_soft_rst <= 1'b1;
        @(posedge i_clk);
        i_soft_rst <= 1'b0;
        rd(`SSDP_OFF_CTRL, d);
        `CHK("ctrl cleared", 24'h0, d)
        rd(`SSDP_OFF_STATUS, d);
        `CHK("soft reset", 24'h000040, d)
        $display("test network and soft reset done");
        stop_test();
    end
endmodule // sync_serial_data_status_tb_top
